// ### hw/sdl_loader.sv
// Serial word loader for a 10-bit voltage output converter
`timescale 1ns/100ps
module sdl_loader (
   // System
   input wire logic clock,
   input wire logic rst,
   // Serial link pins
   input wire logic link_clk,
   input wire logic frame_n,
   input wire logic ser_in,
   // Converter side
   output logic [sdl_pkg::CODE_W-1:0] analog_output,
   output logic [sdl_pkg::MODE_W-1:0] pd_mode,
   output logic power_down,
   output logic out_enable,
   // Status
   output logic frame_busy,
   output logic word_loaded,
   output logic frame_aborted,
   output logic extra_clock,
   output logic [sdl_pkg::STAT_W-1:0] load_count,
   output logic [sdl_pkg::STAT_W-1:0] abort_count
);
   import sdl_pkg::*;

   typedef struct packed {
      logic [1:0] clk_s;
      logic [1:0] frm_s;
      logic [1:0] din_s;
      logic clk_prev;
      logic frm_prev;
      sdl_state_t st;
      logic [CODE_W-1:0] code;
      logic [MODE_W-1:0] mode;
      logic pd;
      logic oe;
      logic busy;
      logic loaded;
      logic aborted;
      logic extra;
      logic [STAT_W-1:0] n_load;
      logic [STAT_W-1:0] n_abort;
   } sdl_top_st_t;

   sdl_top_st_t s_r;
   sdl_top_st_t s_nxt;

   sdl_shift_if sh ();

   sdl_shift u_shift (
      .clock (clock),
      .rst (rst),
      .sh (sh.shifter)
   );

   // Power-down modes are every mode but normal
   function automatic logic is_pd(input logic [MODE_W-1:0] m);
      is_pd = (m != MODE_NORMAL);
   endfunction

   logic clk_fall;
   logic frm_low;
   logic frm_rise;

   always_comb begin
      clk_fall = s_r.clk_prev & ~s_r.clk_s[1];
      frm_low = ~s_r.frm_s[1];
      frm_rise = s_r.frm_s[1] & ~s_r.frm_prev;
   end

   always_comb begin
      s_nxt = s_r;
      sh.clear = 1'b0;
      sh.shift = 1'b0;
      sh.bit_in = s_r.din_s[1];

      // Two-stage synchronisers
      s_nxt.clk_s = {s_r.clk_s[0], link_clk};
      s_nxt.frm_s = {s_r.frm_s[0], frame_n};
      s_nxt.din_s = {s_r.din_s[0], ser_in};
      s_nxt.clk_prev = s_r.clk_s[1];
      s_nxt.frm_prev = s_r.frm_s[1];

      s_nxt.loaded = 1'b0;
      s_nxt.aborted = 1'b0;
      s_nxt.extra = 1'b0;

      case (s_r.st)
         ST_IDLE: begin
            if (frm_low) begin
               sh.clear = 1'b1;
               s_nxt.st = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (frm_rise) begin
               // Partial word dropped, output untouched
               sh.clear = 1'b1;
               s_nxt.aborted = 1'b1;
               s_nxt.n_abort = STAT_W'(s_r.n_abort + 1'b1);
               s_nxt.st = ST_IDLE;
            end else if (frm_low && clk_fall) begin
               sh.shift = 1'b1;
               if (sh.count == LAST_BIT) begin
                  s_nxt.st = ST_LOAD;
               end
            end
         end
         ST_LOAD: begin
            // Word complete one cycle after the sixteenth edge
            s_nxt.code = sh.word[CODE_LO +: CODE_W];
            s_nxt.mode = sh.word[MODE_LO +: MODE_W];
            s_nxt.loaded = 1'b1;
            s_nxt.n_load = STAT_W'(s_r.n_load + 1'b1);
            s_nxt.st = ST_HOLD;
         end
         ST_HOLD: begin
            // Further clocks in this frame are not shifted; each only pulses extra_clock
            if (frm_rise || !frm_low) begin
               s_nxt.st = ST_IDLE;
            end else if (clk_fall) begin
               s_nxt.extra = 1'b1;
            end
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase

      s_nxt.pd = is_pd(s_nxt.mode);
      s_nxt.oe = ~is_pd(s_nxt.mode);
      s_nxt.busy = (s_nxt.st != ST_IDLE);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_r.clk_s <= 2'h3;
         s_r.frm_s <= 2'h3;
         s_r.din_s <= 2'h0;
         s_r.clk_prev <= 1'b1;
         s_r.frm_prev <= 1'b1;
         s_r.st <= ST_IDLE;
         s_r.code <= CODE_RST;
         s_r.mode <= MODE_NORMAL;
         s_r.pd <= 1'b0;
         s_r.oe <= 1'b1;
         s_r.busy <= 1'b0;
         s_r.loaded <= 1'b0;
         s_r.aborted <= 1'b0;
         s_r.extra <= 1'b0;
         s_r.n_load <= '0;
         s_r.n_abort <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign analog_output = s_r.code;
   assign pd_mode = s_r.mode;
   assign power_down = s_r.pd;
   assign out_enable = s_r.oe;
   assign frame_busy = s_r.busy;
   assign word_loaded = s_r.loaded;
   assign frame_aborted = s_r.aborted;
   assign extra_clock = s_r.extra;
   assign load_count = s_r.n_load;
   assign abort_count = s_r.n_abort;
endmodule

// ### hw/sdl_pkg.sv
// Constants and types for the serial converter word loader
// Behaviour
// - Each of the first sixteen falling link clock edges after frame start shifts one data bit into 16-bit register.
// - Host pulls active-low frame select to start; shifting happens only while it stays low.
// - On the sixteenth clock of a frame the word updates the output register.
// - Frame select rising before sixteenth edge aborts; partial word dropped, output kept.
// - Reset puts output code at zero volts until first complete valid frame.
// - Output register holds a 10-bit code selecting one of 1024 levels.
// - A mode field in the word selects power-down, which stops normal output.
package sdl_pkg;
   localparam int WORD_W = 16;
   localparam int CODE_W = 10;
   localparam int MODE_W = 2;
   localparam int CNT_W = 5;
   localparam int STAT_W = 16;
   localparam int MODE_LO = 12;
   localparam int CODE_LO = 2;
   localparam logic [CNT_W-1:0] LAST_BIT = 5'h0F;
   localparam logic [CODE_W-1:0] CODE_RST = 10'h000;
   localparam logic [MODE_W-1:0] MODE_NORMAL = 2'h0;
   localparam logic [MODE_W-1:0] MODE_PD_LOW_R = 2'h1;
   localparam logic [MODE_W-1:0] MODE_PD_HIGH_R = 2'h2;
   localparam logic [MODE_W-1:0] MODE_PD_OPEN = 2'h3;
   localparam int LINK_CLK_MAX_KHZ = 30000;
   localparam int SYS_CLK_KHZ = 125000;
   localparam int LINK_HALF_MIN_CYC = SYS_CLK_KHZ / (2 * LINK_CLK_MAX_KHZ);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SHIFT,
      ST_LOAD,
      ST_HOLD
   } sdl_state_t;
endpackage

// ### hw/sdl_shift_if.sv
// Carrier between the loader control and its shift register
`timescale 1ns/100ps
interface sdl_shift_if;
   import sdl_pkg::*;
   logic clear;
   logic shift;
   logic bit_in;
   logic [WORD_W-1:0] word;
   logic [CNT_W-1:0] count;

   modport ctrl (
      output clear,
      output shift,
      output bit_in,
      input word,
      input count
   );
   modport shifter (
      input clear,
      input shift,
      input bit_in,
      output word,
      output count
   );
endinterface

// ### hw/sdl_shift.sv
// Input shift register with bit counter
`timescale 1ns/100ps
module sdl_shift (
   // System
   input wire logic clock,
   input wire logic rst,
   // Control side
   sdl_shift_if.shifter sh
);
   import sdl_pkg::*;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic [CNT_W-1:0] count;
   } sdl_shift_st_t;

   sdl_shift_st_t s_r;
   sdl_shift_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (sh.clear) begin
         s_nxt.word = '0;
         s_nxt.count = '0;
      end else if (sh.shift) begin
         // MSB first
         s_nxt.word = {s_r.word[WORD_W-2:0], sh.bit_in};
         s_nxt.count = CNT_W'(s_r.count + 1'b1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sh.word = s_r.word;
   assign sh.count = s_r.count;
endmodule

// ### verification/sdl_checker.sv
// Port assertions for the serial word loader
`timescale 1ns/100ps
module sdl_checker (
   // System
   input wire logic clock,
   input wire logic rst,
   // Watched outputs
   input wire logic [sdl_pkg::CODE_W-1:0] analog_output,
   input wire logic [sdl_pkg::MODE_W-1:0] pd_mode,
   input wire logic power_down,
   input wire logic out_enable,
   input wire logic frame_busy,
   input wire logic word_loaded,
   input wire logic frame_aborted
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   load_pulse_a: assert property (word_loaded |=> !word_loaded)
      else $error("load pulse long");
   code_on_load_a: assert property ($changed(analog_output) |-> word_loaded)
      else $error("code moved");
   mode_on_load_a: assert property ($changed(pd_mode) |-> word_loaded)
      else $error("mode moved");
   abort_keep_a: assert property (frame_aborted |-> $stable(analog_output) && !word_loaded
      ##1 !frame_aborted) else $error("abort changed code");
   abort_idle_a: assert property (frame_aborted |-> !frame_busy)
      else $error("busy after abort");
   rst_zero_a: assert property ($past(rst) |-> analog_output == 10'h000 && pd_mode == 2'h0)
      else $error("reset code");
   pd_flag_a: assert property (power_down == (pd_mode != 2'h0) && out_enable == !power_down)
      else $error("power down flags");
   load_frame_a: assert property (word_loaded |-> $past(frame_busy))
      else $error("load outside frame");
   cover property (word_loaded && power_down);
   cover property (frame_aborted);
   cover property (word_loaded && analog_output == 10'h3FF);
endmodule
bind sdl_loader sdl_checker i_sdl_checker(.clock(clock), .rst(rst),
   .analog_output(analog_output), .pd_mode(pd_mode), .power_down(power_down),
   .out_enable(out_enable), .frame_busy(frame_busy), .word_loaded(word_loaded),
   .frame_aborted(frame_aborted));

// ### verification/sdl_host.sv
// Host model driving the serial write link
`timescale 1ns/100ps
module sdl_host (
   // System
   input wire logic clock,
   // Link pins
   output logic link_clk,
   output logic frame_n,
   output logic ser_in
);
   initial begin
      link_clk = 1;
      frame_n = 1;
      ser_in = 0;
   end
   task automatic hc(int n);
      repeat (n) @(negedge clock);
   endtask
   // Frame of n falls, MSB first, 160 ns link period
   task automatic send(logic [15:0] w, int n);
      frame_n = 0;
      hc(5);
      for (int i = 0; i < n; i++) begin
         ser_in = (i < 16) ? w[15 - i] : 1'b0;
         hc(5);
         link_clk = 0;
         hc(10);
         link_clk = 1;
         hc(5);
      end
      ser_in = ~ser_in;
      frame_n = 1;
      hc(5);
   endtask
endmodule

// ### verification/sdl_loader_tb_top.sv
// Bench for the serial word loader
`timescale 1ns/100ps
module sdl_loader_tb_top;
   import sdl_pkg::*;
   typedef struct {logic [15:0] w; int n; logic [9:0] c; logic [1:0] m;} sdl_row_t;
   sdl_row_t rows[6] = '{'{16'h0FFC, 16, 10'h3FF, 2'h0}, '{16'h1004, 16, 10'h001, 2'h1},
      '{16'h2008, 16, 10'h002, 2'h2}, '{16'h300C, 16, 10'h003, 2'h3},
      '{16'h0A55, 5, 10'h003, 2'h3}, '{16'h0A55, 17, 10'h295, 2'h0}};
   logic clock = 0;
   logic rst = 1;
   logic link_clk, frame_n, ser_in, frame_busy;
   logic power_down, out_enable, extra_clock;
   logic [CODE_W-1:0] analog_output;
   logic [MODE_W-1:0] pd_mode;
   logic [STAT_W-1:0] load_count, abort_count;
   int fail_count = 0;
   int compares = 0;
   int extra_seen = 0;
   always #4 clock = ~clock;
   always @(negedge clock) if (extra_clock === 1'b1) extra_seen++;
   sdl_host i_sdl_host(.clock(clock), .link_clk(link_clk), .frame_n(frame_n), .ser_in(ser_in));
   sdl_loader i_sdl_loader(.clock(clock), .rst(rst), .link_clk(link_clk), .frame_n(frame_n),
      .ser_in(ser_in), .analog_output(analog_output), .pd_mode(pd_mode),
      .power_down(power_down), .out_enable(out_enable), .frame_busy(frame_busy),
      .word_loaded(), .frame_aborted(), .extra_clock(extra_clock), .load_count(load_count),
      .abort_count(abort_count));
   task automatic chk(string s, logic [15:0] e, logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic run(logic [15:0] w, int n);
      int t = 0;
      i_sdl_host.send(w, n);
      while (frame_busy !== 1'b0 && t < 50) begin
         @(negedge clock);
         t++;
      end
      if (t == 50) begin
         fail_count++;
         end_of_test;
      end
   endtask
   task automatic outs(logic [9:0] c, logic [1:0] m);
      chk("code", 16'(c), 16'(analog_output));
      chk("mode", 16'(m), 16'(pd_mode));
      chk("power down", 16'(m != 2'h0), 16'(power_down));
      chk("output enable", 16'(m == 2'h0), 16'(out_enable));
   endtask
   task automatic do_rst;
      rst = 1;
      repeat (6) @(negedge clock);
      rst = 0;
      repeat (4) @(negedge clock);
   endtask
   initial begin
      do_rst;
      for (int i = 0; i < 6; i++) begin
         run(rows[i].w, rows[i].n);
         outs(rows[i].c, rows[i].m);
         $display("row %0d done", i);
      end
      chk("loads", 16'h0005, load_count);
      chk("aborts", 16'h0001, abort_count);
      chk("extras", 16'h0001, 16'(extra_seen));
      do_rst;
      outs(10'h000, 2'h0);
      run(16'h0FFC, 15);
      outs(10'h000, 2'h0);
      $display("reset and abort done");
      end_of_test;
   end
endmodule
